// ---- verilog/pdsl_defs.vh ----
`ifndef PDSL_DEFS_VH
`define PDSL_DEFS_VH

// register byte addresses
`define PDSL_ADDR_DEVSTAT      8'hC8
`define PDSL_ADDR_LINKCAP      8'hCC
`define PDSL_ADDR_DEVCTRL      8'hD8
`define PDSL_ADDR_IRQ_STATUS   8'hE0
`define PDSL_ADDR_IRQ_MASK     8'hE4
`define PDSL_ADDR_OVERRIDE     8'hE8
`define PDSL_ADDR_OVR_VALID    8'hEC

// device status fields
`define PDSL_BIT_CORR          16
`define PDSL_BIT_NONFATAL      17
`define PDSL_BIT_FATAL         18
`define PDSL_BIT_UNSUP         19
`define PDSL_BIT_AUXPWR        20
`define PDSL_BIT_TXPEND        21

// link capability fields
`define PDSL_SPEED_LSB         0
`define PDSL_SPEED_MSB         3
`define PDSL_WIDTH_LSB         4
`define PDSL_WIDTH_MSB         9
`define PDSL_ASPM_LSB          10
`define PDSL_ASPM_MSB          11
`define PDSL_L0S_LSB           12
`define PDSL_L0S_MSB           14
`define PDSL_L1_LSB            15
`define PDSL_L1_MSB            17
`define PDSL_BIT_DLLACT        20
`define PDSL_BIT_BWNOTIFY      21
`define PDSL_PORT_LSB          24
`define PDSL_PORT_MSB          31

// reset values
`define PDSL_RST_SPEED         4'h2
`define PDSL_RST_WIDTH         6'h01
`define PDSL_RST_ASPM          2'h0
`define PDSL_RST_L0S           3'h3
`define PDSL_RST_L1            3'h0
`define PDSL_RST_ENABLES       4'h0

// override word layout: speed[3:0] aspm[5:4] l0s[8:6] l1[11:9] port[19:12]
`define PDSL_OVR_WIDTH         20

`endif

// ---- verilog/pdsl_err_flags.v ----
`include "pdsl_defs.vh"

// sticky write-one-to-clear flags; a set in the clear cycle wins
module pdsl_err_flags #(
  parameter N = 4
) (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire [N-1:0] set_pulse,
  input  wire         clr_en,
  input  wire [N-1:0] clr_mask,
  output reg  [N-1:0] flags
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= {N{1'b0}};
    end else begin
      flags <= (flags & ~(clr_en ? clr_mask : {N{1'b0}})) | set_pulse;
    end
  end

endmodule

// ---- verilog/pdsl_ovr_regs.v ----
`include "pdsl_defs.vh"

// replacement values for capability defaults, loaded by smbus or eeprom
module pdsl_ovr_regs #(
  parameter [7:0] PORT_INDEX = 8'h00
) (
  input  wire                      hclk,
  input  wire                      hresetn,
  input  wire                      load_en,
  input  wire [`PDSL_OVR_WIDTH-1:0] load_data,
  output reg  [3:0]                speed,
  output reg  [1:0]                aspm,
  output reg  [2:0]                l0s,
  output reg  [2:0]                l1,
  output reg  [7:0]                port_num,
  output reg                       loaded
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed    <= `PDSL_RST_SPEED;
      aspm     <= `PDSL_RST_ASPM;
      l0s      <= `PDSL_RST_L0S;
      l1       <= `PDSL_RST_L1;
      port_num <= PORT_INDEX;
      loaded   <= 1'b0;
    end else if (load_en) begin
      speed    <= load_data[3:0];
      aspm     <= load_data[5:4];
      l0s      <= load_data[8:6];
      l1       <= load_data[11:9];
      port_num <= load_data[19:12];
      loaded   <= 1'b1;
    end
  end

endmodule

// ---- verilog/pdsl_regbank.v ----
`include "pdsl_defs.vh"

// Behaviour
// [RULE1] correctable error sets bit 16; write one clears; resets to zero
// [RULE2] non-fatal error sets bit 17; write one clears; resets to zero
// [RULE3] fatal error sets bit 18; write one clears; resets to zero
// [RULE4] unsupported request sets bit 19; write one clears; resets to zero
// [RULE5] error flags latch regardless of the reporting enable bits
// [RULE6] per-class enables gate only error messages; reset to disabled
// [RULE7] bit 20 reports aux power present, reset value one
// [RULE8] transactions-pending bit 21 always reads zero
// [RULE9] max link speed bits 3:0 reset to 5 Gb/s code
// [RULE10] max link width bits 9:4 reset to single lane
// [RULE11] aspm support bits 11:10 reset to zero
// [RULE12] l0s exit latency bits 14:12 reset to 256-512 ns code
// [RULE13] l1 exit latency bits 17:15 reset to zero
// [RULE14] speed, aspm, latencies, port number replaceable via smbus or eeprom load
// [RULE15] link-active reporting bit 20 zero upstream, one on hot-plug downstream
// [RULE16] bandwidth notify bit 21 zero upstream, one downstream
// [RULE17] port number bits 31:24 reset to own port index
// [RULE18] reserved bits read zero, writes ignored
module pdsl_regbank #(
  parameter [7:0] PORT_INDEX  = 8'h00,
  parameter       IS_UPSTREAM = 1,
  parameter       HOT_PLUG    = 0
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        err_corr,
  input  wire        err_nonfatal,
  input  wire        err_fatal,
  input  wire        err_unsup,
  input  wire        aux_power,
  input  wire        smbus_load,
  input  wire [19:0] smbus_data,
  input  wire        eeprom_load,
  input  wire [19:0] eeprom_data,
  output reg         msg_corr,
  output reg         msg_nonfatal,
  output reg         msg_fatal,
  output reg         msg_unsup,
  output reg         irq
);

  // address phase capture
  reg        dp_valid;
  reg        dp_write;
  reg [7:0]  dp_addr;

  wire       ap_take = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else if (hready) begin
      dp_valid <= ap_take;
      dp_write <= hwrite;
      dp_addr  <= haddr[7:0];
    end
  end

  wire wr_now = dp_valid & dp_write;

  function wr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      wr_hit = (a == target);
    end
  endfunction

  // reporting enables and interrupt mask
  reg [3:0] rpt_en;
  reg [5:0] irq_mask;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rpt_en   <= `PDSL_RST_ENABLES; // [RULE6]
      irq_mask <= 6'h00;
    end else if (wr_now) begin
      if (wr_hit(dp_addr, `PDSL_ADDR_DEVCTRL))
        rpt_en <= hwdata[3:0];
      if (wr_hit(dp_addr, `PDSL_ADDR_IRQ_MASK))
        irq_mask <= hwdata[5:0];
    end
  end

  // error detected flags
  wire [3:0] err_in = {err_unsup, err_fatal, err_nonfatal, err_corr};
  wire [3:0] err_flags;

  pdsl_err_flags #(
    .N (4)
  ) u_err (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set_pulse (err_in), // [RULE5]
    .clr_en    (wr_now & wr_hit(dp_addr, `PDSL_ADDR_DEVSTAT)),
    .clr_mask  (hwdata[`PDSL_BIT_UNSUP:`PDSL_BIT_CORR]), // [RULE1] [RULE2] [RULE3] [RULE4]
    .flags     (err_flags)
  );

  // error messages gated by enables only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      msg_corr     <= 1'b0;
      msg_nonfatal <= 1'b0;
      msg_fatal    <= 1'b0;
      msg_unsup    <= 1'b0;
    end else begin
      msg_corr     <= err_corr & rpt_en[0]; // [RULE6]
      msg_nonfatal <= err_nonfatal & rpt_en[1];
      msg_fatal    <= err_fatal & rpt_en[2];
      msg_unsup    <= err_unsup & rpt_en[3];
    end
  end

  // capability overrides; smbus has priority over eeprom
  wire [3:0] ovr_speed;
  wire [1:0] ovr_aspm;
  wire [2:0] ovr_l0s;
  wire [2:0] ovr_l1;
  wire [7:0] ovr_port;
  wire       ovr_loaded;

  pdsl_ovr_regs #(
    .PORT_INDEX (PORT_INDEX)
  ) u_ovr (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .load_en   (smbus_load | eeprom_load), // [RULE14]
    .load_data (smbus_load ? smbus_data : eeprom_data),
    .speed     (ovr_speed),
    .aspm      (ovr_aspm),
    .l0s       (ovr_l0s),
    .l1        (ovr_l1),
    .port_num  (ovr_port),
    .loaded    (ovr_loaded)
  );

  // aux power level and capability events
  reg aux_q;
  reg ovr_loaded_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_q        <= 1'b1; // [RULE7]
      ovr_loaded_q <= 1'b0;
    end else begin
      aux_q        <= aux_power;
      ovr_loaded_q <= ovr_loaded;
    end
  end

  // interrupt status: four errors, aux power change, first override load after reset
  wire [5:0] irq_events = {ovr_loaded & ~ovr_loaded_q, aux_q ^ aux_power, err_in};
  wire [5:0] irq_status;

  pdsl_err_flags #(
    .N (6)
  ) u_irq (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .set_pulse (irq_events),
    .clr_en    (wr_now & wr_hit(dp_addr, `PDSL_ADDR_IRQ_STATUS)),
    .clr_mask  (hwdata[5:0]),
    .flags     (irq_status)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status & irq_mask);
  end

  // register images
  wire       dll_cap  = (IS_UPSTREAM == 0) && (HOT_PLUG != 0); // [RULE15]
  wire       bw_cap   = (IS_UPSTREAM == 0); // [RULE16]

  wire [31:0] devstat_word = {10'h000, // [RULE18]
                              1'b0, // [RULE8]
                              aux_q, // [RULE7]
                              err_flags,
                              16'h0000};

  wire [31:0] linkcap_word = {ovr_port, // [RULE17]
                              2'b00, // [RULE18]
                              bw_cap,
                              dll_cap,
                              2'b00,
                              ovr_l1, // [RULE13]
                              ovr_l0s, // [RULE12]
                              ovr_aspm, // [RULE11]
                              `PDSL_RST_WIDTH, // [RULE10]
                              ovr_speed}; // [RULE9]

  reg [31:0] next_rdata;

  always @* begin
    case (haddr[7:0])
      `PDSL_ADDR_DEVSTAT:    next_rdata = devstat_word;
      `PDSL_ADDR_LINKCAP:    next_rdata = linkcap_word;
      `PDSL_ADDR_DEVCTRL:    next_rdata = {28'h0000000, rpt_en};
      `PDSL_ADDR_IRQ_STATUS: next_rdata = {26'h0, irq_status};
      `PDSL_ADDR_IRQ_MASK:   next_rdata = {26'h0, irq_mask};
      `PDSL_ADDR_OVR_VALID:  next_rdata = {31'h0, ovr_loaded};
      default:               next_rdata = 32'h00000000;
    endcase
  end

  // zero wait states; read data registered at the address phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_take & ~hwrite)
        hrdata <= next_rdata;
    end
  end

endmodule

// ---- testbench/pdsl_regbank_monitor.sv ----
module pdsl_regbank_monitor #(
  parameter IS_UPSTREAM = 1,
  parameter HOT_PLUG    = 0
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        err_corr,
  input wire        err_nonfatal,
  input wire        err_fatal,
  input wire        err_unsup,
  input wire        msg_corr,
  input wire        msg_nonfatal,
  input wire        msg_fatal,
  input wire        msg_unsup,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking mcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_take = hsel && hready && htrans[1] && !hwrite;
  wire rd_st   = rd_take && (haddr[7:0] == 8'hC8);
  wire rd_cap  = rd_take && (haddr[7:0] == 8'hCC);
  chk_msg_corr_cause: assert property (msg_corr |-> $past(err_corr))
    else $error("correctable message without event");
  chk_msg_nonfatal_cause: assert property (msg_nonfatal |-> $past(err_nonfatal))
    else $error("non-fatal message without event");
  chk_msg_fatal_cause: assert property (msg_fatal |-> $past(err_fatal))
    else $error("fatal message without event");
  chk_msg_unsup_cause: assert property (msg_unsup |-> $past(err_unsup))
    else $error("unsupported message without event");
  chk_txpend_zero: assert property (rd_st |=> hrdata[21] == 1'b0)
    else $error("pending bit read as one");
  chk_status_rsvd_zero: assert property (rd_st |=> hrdata[31:22] == 10'h000)
    else $error("status reserved bits not zero");
  chk_cap_width_fixed: assert property (rd_cap |=> hrdata[9:4] == 6'h01)
    else $error("link width not single lane");
  chk_cap_dllact_bit: assert property (rd_cap |=> hrdata[20] == (!IS_UPSTREAM && HOT_PLUG))
    else $error("link active reporting bit wrong");
  chk_cap_bw_bit: assert property (rd_cap |=> hrdata[21] == !IS_UPSTREAM)
    else $error("bandwidth notify bit wrong");
  chk_cap_rsvd_zero: assert property (rd_cap |=> hrdata[23:22] == 2'h0 && hrdata[19:18] == 2'h0)
    else $error("capability reserved bits not zero");
  cover property (rd_st);
  cover property (msg_fatal);
  cover property ($rose(irq));
endmodule

bind pdsl_regbank pdsl_regbank_monitor #(.IS_UPSTREAM(IS_UPSTREAM), .HOT_PLUG(HOT_PLUG)) pdsl_regbank_monitor_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .err_corr(err_corr), .err_nonfatal(err_nonfatal),
  .err_fatal(err_fatal), .err_unsup(err_unsup), .msg_corr(msg_corr), .msg_nonfatal(msg_nonfatal),
  .msg_fatal(msg_fatal), .msg_unsup(msg_unsup), .irq(irq));

// ---- testbench/pcie_dev_status_link_cap_test.sv ----
module pcie_dev_status_link_cap_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [19:0] DEF = {8'h02, 3'h0, 3'h3, 2'h0, 4'h2};
  reg         hclk, hresetn, hsel, hwrite, aux_power, smbus_load, eeprom_load;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [3:0]  errv, en, msk, ev, clr;
  reg  [19:0] smbus_data, eeprom_data;
  wire [31:0] hrdata;
  wire [3:0]  msgv;
  wire        hreadyout, hresp, irq;
  integer     err_total, compares, i;
  pdsl_regbank #(.PORT_INDEX(8'h02), .IS_UPSTREAM(0), .HOT_PLUG(1)) pdsl_regbank_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .err_corr(errv[0]), .err_nonfatal(errv[1]), .err_fatal(errv[2]), .err_unsup(errv[3]),
    .aux_power(aux_power), .smbus_load(smbus_load), .smbus_data(smbus_data), .eeprom_load(eeprom_load),
    .eeprom_data(eeprom_data), .msg_corr(msgv[0]), .msg_nonfatal(msgv[1]), .msg_fatal(msgv[2]),
    .msg_unsup(msgv[3]), .irq(irq));
  function [31:0] cap(input [19:0] o);
    cap = {o[19:12], 2'h0, 1'b1, 1'b1, 2'h0, o[11:9], o[8:6], o[5:4], 6'h01, o[3:0]};
  endfunction
  function [31:0] stat(input [3:0] f, input a);
    stat = {11'h000, a, f, 16'h0000};
  endfunction
  task chk(input string n, input [31:0] e, input [31:0] s);
    compares = compares + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one single transfer, idle cycle before it so reads never follow a write directly
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task summarize;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    err_total = 0;
    compares = 0;
    {hresetn, hsel, hwrite, smbus_load, eeprom_load, haddr, hwdata, htrans, errv} = 0;
    {smbus_data, eeprom_data} = 0;
    aux_power = 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    void'($urandom(32'h87932cb5));
    xfer(0, 8'hC8, 0);
    chk("status reset", stat(4'h0, 1'b1), rd);
    xfer(0, 8'hCC, 0);
    chk("cap reset", cap(DEF), rd);
    xfer(1, 8'hCC, 32'hFFFFFFFF);
    xfer(0, 8'hCC, 0);
    chk("cap write ignored", cap(DEF), rd);
    xfer(0, 8'hD8, 0);
    chk("enables reset", 32'h0, rd);
    xfer(0, 8'hF0, 0);
    chk("unmapped", 32'h0, rd);
    $display("reset values test done");
    for (i = 0; i < 24; i = i + 1) begin
      en = $urandom;
      msk = $urandom;
      ev = (i == 0) ? 4'hF : $urandom;
      clr = (i == 1) ? 4'hF : $urandom;
      if (i == 0) en = 4'h0;
      xfer(1, 8'hD8, {28'h0, en});
      xfer(1, 8'hE4, {28'h0, msk});
      @(posedge hclk);
      errv <= ev;
      @(posedge hclk);
      errv <= 4'h0;
      #1;
      chk("messages", {28'h0, ev & en}, {28'h0, msgv});
      @(posedge hclk);
      #1;
      chk("irq set", {31'h0, |(ev & msk)}, {31'h0, irq});
      xfer(0, 8'hC8, 0);
      chk("flags latched", stat(ev, 1'b1), rd);
      xfer(0, 8'hE0, 0);
      chk("irq status", {28'h0, ev}, rd);
      chk("response", 32'h1, {30'h0, hresp, hreadyout});
      xfer(1, 8'hC8, {12'h000, clr, 16'h0000});
      xfer(0, 8'hC8, 0);
      chk("flags cleared", stat(ev & ~clr, 1'b1), rd);
      xfer(1, 8'hC8, 32'hFFFFFFFF);
      xfer(1, 8'hE0, 32'hFFFFFFFF);
      @(posedge hclk);
      #1;
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    $display("error flag test done");
    @(posedge hclk);
    eeprom_load <= 1'b1;
    eeprom_data <= $urandom;
    @(posedge hclk);
    eeprom_load <= 1'b0;
    xfer(0, 8'hCC, 0);
    chk("eeprom override", cap(eeprom_data), rd);
    @(posedge hclk);
    {smbus_load, eeprom_load} <= 2'h3;
    smbus_data <= $urandom;
    eeprom_data <= $urandom;
    @(posedge hclk);
    {smbus_load, eeprom_load} <= 2'h0;
    xfer(0, 8'hCC, 0);
    chk("smbus override", cap(smbus_data), rd);
    xfer(0, 8'hEC, 0);
    chk("override loaded", 32'h1, rd);
    aux_power <= 1'b0;
    xfer(0, 8'hC8, 0);
    chk("aux power absent", stat(4'h0, 1'b0), rd);
    $display("override and aux test done");
    summarize;
  end
endmodule
